/* File: rtl/bifs_sequencer.sv */
// Purpose: Ignition, retry and lockout sequencer of a modulating gas burner
// Assumes: Contacts are asynchronous pins; analog values arrive as settled samples
// Notes: Power-on reset restarts from board check; display code is a small enum
`timescale 1ns/10ps
module bifs_sequencer #(
   parameter int unsigned TICK_CYCLES = bifs_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Contacts and switches
   input wire bifs_pkg::bifs_pins_s i_pins,
   // Analog samples, percent of full scale and flame current in 0.1 uA
   input wire logic [7:0] i_firing_rate_input,
   input wire logic [7:0] i_act_position,
   input wire logic [7:0] i_flame_current,
   // Burner drive
   output bifs_pkg::bifs_drive_s o_drive,
   output logic [7:0] o_act_cmd,
   // Display and alerts
   output bifs_pkg::bifs_code_e o_code,
   output logic o_lockout,
   output logic [bifs_pkg::AL_W-1:0] o_alerts
);

   // ************************************************
   // Input synchronisers
   // ************************************************
   localparam int unsigned PW = $bits(bifs_pkg::bifs_pins_s);
   logic [PW-1:0] pin_meta;
   logic [PW-1:0] pin_sync;
   bifs_pkg::bifs_pins_s p;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= i_pins;
         pin_sync <= pin_meta;
      end
   end
   assign p = bifs_pkg::bifs_pins_s'(pin_sync);

   // ************************************************
   // Seconds tick
   // ************************************************
   logic tick;

   bifs_sec_tick #(
      .CYCLES(TICK_CYCLES)
   ) i_bifs_sec_tick (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .o_tick(tick)
   );

   // ************************************************
   // State machine
   // ************************************************
   typedef enum logic [8:0] {
      ST_BOOT = 9'h001,
      ST_OFF = 9'h002,
      ST_PREPURGE = 9'h004,
      ST_TRIAL = 9'h008,
      ST_WARMUP = 9'h010,
      ST_RUN = 9'h020,
      ST_RETRY = 9'h040,
      ST_POSTPURGE = 9'h080,
      ST_LOCKOUT = 9'h100
   } bifs_state_e;

   bifs_state_e state;
   bifs_state_e next_state;
   logic [bifs_pkg::SEC_W-1:0] secs;
   logic [bifs_pkg::SEC_W-1:0] lock_len;
   bifs_pkg::bifs_code_e lock_code;
   bifs_pkg::bifs_code_e next_lock_code;
   logic [bifs_pkg::SEC_W-1:0] next_lock_len;
   logic [2:0] fails;
   logic limited_low;
   logic flame_lost;
   logic trial_fail;
   logic fault;
   logic demand;
   logic timer_done;
   logic enter;

   // Firing refused without the enable circuit, even with non-zero demand
   assign demand = p.heat_call && (i_firing_rate_input != 8'h00) && p.enable_ok;
   assign timer_done = (secs >= lock_len);

   // Lockout causes; priority follows list order, lowest index wins
   always_comb begin
      fault = 1'b1;
      next_lock_code = bifs_pkg::BIFS_CODE_LO_LIMIT;
      next_lock_len = bifs_pkg::LOCK_10_S;
      if (!p.limit_ok || !p.rollout_ok) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_LIMIT;
         next_lock_len = bifs_pkg::LOCK_10_S;
      end else if (p.heat_call && !p.enable_ok && i_firing_rate_input != 8'h00) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_ENABLE;
         next_lock_len = bifs_pkg::LOCK_0_S;
      end else if (p.sec_lockout) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_SECONDARY;
         next_lock_len = bifs_pkg::LOCK_10_S;
      end else if (p.air_low || (state == ST_PREPURGE && secs == 12'h000 && p.air_switch
                   && !p.act_at_park)) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_LOW_AIR;
         next_lock_len = bifs_pkg::LOCK_30_S;
      end else if (p.air_high) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_HIGH_AIR;
         next_lock_len = bifs_pkg::LOCK_30_S;
      end else if (p.air_gas_mismatch) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_LOW_AIR;
         next_lock_len = bifs_pkg::LOCK_30_S;
      end else if ((state == ST_WARMUP || state == ST_RUN) && !p.air_switch
                   && p.heat_call) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_AIR_SWITCH;
         next_lock_len = bifs_pkg::LOCK_HOUR_S;
      end else if ((state == ST_PREPURGE && secs == bifs_pkg::PREPURGE_S && !p.act_at_park)
                   || (state == ST_RUN && i_firing_rate_input == bifs_pkg::PCT_FULL
                   && secs >= bifs_pkg::LOCK_10_S && !p.act_at_full)) begin
         next_lock_code = bifs_pkg::BIFS_CODE_LO_VALVE;
         next_lock_len = bifs_pkg::LOCK_10_S;
      end else begin
         fault = 1'b0;
      end
   end

   assign flame_lost = (state == ST_WARMUP || state == ST_RUN) && !p.flame;
   assign trial_fail = (state == ST_TRIAL) && tick && (secs + 1'b1 >= bifs_pkg::TRIAL_S)
                       && !p.flame;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_BOOT: begin
            if (p.board_fail) begin
               next_state = ST_LOCKOUT;
            end else if (secs >= bifs_pkg::BOARD_CHECK_S) begin
               next_state = ST_OFF;
            end
         end
         ST_OFF: begin
            if (fault && p.heat_call) begin
               next_state = ST_LOCKOUT;
            end else if (demand) begin
               next_state = ST_PREPURGE;
            end
         end
         ST_PREPURGE, ST_TRIAL, ST_WARMUP, ST_RUN, ST_RETRY: begin
            if (fault) begin
               next_state = ST_LOCKOUT;
            end else if (!demand) begin
               next_state = ST_POSTPURGE;
            end else if (state == ST_PREPURGE && secs >= bifs_pkg::PREPURGE_S) begin
               next_state = ST_TRIAL;
            end else if (state == ST_TRIAL && p.flame) begin
               next_state = ST_WARMUP;
            end else if (trial_fail || flame_lost) begin
               if (fails + 1'b1 >= bifs_pkg::MAX_TRIALS && trial_fail) begin
                  next_state = ST_LOCKOUT;
               end else begin
                  next_state = ST_RETRY;
               end
            end else if (state == ST_WARMUP && secs >= bifs_pkg::WARMUP_S) begin
               next_state = ST_RUN;
            end else if (state == ST_RETRY && secs >= bifs_pkg::INTERPURGE_S) begin
               next_state = ST_TRIAL;
            end
         end
         ST_POSTPURGE: begin
            if (secs >= bifs_pkg::POSTPURGE_S) begin
               next_state = ST_OFF;
            end
         end
         ST_LOCKOUT: begin
            // Heater held off for the whole period, whatever clears in between
            if (timer_done) begin
               next_state = p.heat_call ? ST_PREPURGE : ST_OFF;
            end
         end
      endcase
   end

   assign enter = (next_state != state);

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_BOOT;
      end else begin
         state <= next_state;
      end
   end

   // Seconds in current state; reset on every transition
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         secs <= '0;
      end else if (enter) begin
         secs <= '0;
      end else if (tick && secs != '1) begin
         secs <= secs + 1'b1;
      end
   end

   // Lockout code and period captured on entry
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lock_code <= bifs_pkg::BIFS_CODE_LO_BOARD;
         lock_len <= bifs_pkg::LOCK_10_S;
      end else if (enter && next_state == ST_LOCKOUT) begin
         if (state == ST_BOOT) begin
            lock_code <= bifs_pkg::BIFS_CODE_LO_BOARD;
            lock_len <= bifs_pkg::LOCK_10_S;
         end else if (fault) begin
            lock_code <= next_lock_code;
            lock_len <= next_lock_len;
         end else begin
            lock_code <= bifs_pkg::BIFS_CODE_LO_FAILED_IGN;
            lock_len <= bifs_pkg::LOCK_HOUR_S;
         end
      end else if (state == ST_BOOT) begin
         lock_len <= bifs_pkg::BOARD_CHECK_S;
      end
   end

   // Failed-trial counter
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fails <= '0;
      end else if (state == ST_TRIAL && p.flame) begin
         fails <= '0;
      end else if (state == ST_LOCKOUT && enter) begin
         fails <= '0;
      end else if (enter && next_state == ST_RETRY) begin
         fails <= fails + 1'b1;
      end
   end

   // Low-fire adaptation lasts until the heat call ends
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         limited_low <= 1'b0;
      end else if (flame_lost && i_firing_rate_input <= bifs_pkg::LOW_FIRE_LIMIT) begin
         limited_low <= 1'b1;
      end else if (!p.heat_call) begin
         limited_low <= 1'b0;
      end
   end

   // ************************************************
   // Alerts
   // ************************************************
   logic [bifs_pkg::AL_W-1:0] next_alerts;
   logic [8:0] derated;
   logic firing;

   assign firing = (state == ST_WARMUP || state == ST_RUN);
   // Actuator more than 20 percent of input below the input, scaled by 100
   assign derated = {1'b0, i_firing_rate_input} - {1'b0, i_act_position};

   always_comb begin
      next_alerts = o_alerts;
      if (enter && state == ST_TRIAL && next_state != ST_WARMUP) begin
         next_alerts[bifs_pkg::AL_FAILED_IGN] = 1'b1;
      end
      if (enter && firing && flame_lost) begin
         next_alerts[bifs_pkg::AL_LOST_FLAME] = 1'b1;
      end
      if (state == ST_TRIAL && p.flame) begin
         next_alerts[bifs_pkg::AL_FAILED_IGN] = 1'b0;
      end
      next_alerts[bifs_pkg::AL_COMB_AIR] = firing && p.air_low
         && i_act_position < i_firing_rate_input
         && 16'(derated) * 16'(bifs_pkg::PCT_FULL)
            > 16'(i_firing_rate_input) * 16'(bifs_pkg::DERATE_PCT);
      next_alerts[bifs_pkg::AL_LIMITED_LOW] = limited_low;
      next_alerts[bifs_pkg::AL_WEAK_FLAME] = firing && p.flame
         && i_flame_current < bifs_pkg::WEAK_FLAME_NA;
      next_alerts[bifs_pkg::AL_INDUCER] = p.inducer_stuck;
      next_alerts[bifs_pkg::AL_NULL_CHECK] = p.null_bad;
      if (state == ST_OFF && !p.heat_call) begin
         next_alerts[bifs_pkg::AL_FAILED_IGN] = 1'b0;
         next_alerts[bifs_pkg::AL_LOST_FLAME] = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alerts <= '0;
      end else begin
         o_alerts <= next_alerts;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   logic [7:0] floor_rate;

   assign floor_rate = limited_low ? bifs_pkg::LIMITED_FLOOR : 8'h00;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_drive <= '0;
         o_act_cmd <= 8'h00;
         o_lockout <= 1'b0;
      end else begin
         o_drive.inducer <= next_state inside {ST_PREPURGE, ST_TRIAL, ST_WARMUP, ST_RUN,
                                               ST_RETRY, ST_POSTPURGE};
         o_drive.igniter <= (next_state == ST_TRIAL);
         o_drive.gas_valve <= next_state inside {ST_TRIAL, ST_WARMUP, ST_RUN};
         o_drive.act_park <= !(next_state inside {ST_TRIAL, ST_WARMUP, ST_RUN});
         o_act_cmd <= (next_state != ST_RUN) ? 8'h00 :
                      (i_firing_rate_input < floor_rate) ? floor_rate
                                                         : i_firing_rate_input;
         o_lockout <= (next_state == ST_LOCKOUT);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_code <= bifs_pkg::BIFS_CODE_BOARD_CHECK;
      end else begin
         unique case (state)
            ST_BOOT: o_code <= bifs_pkg::BIFS_CODE_BOARD_CHECK;
            ST_OFF: o_code <= bifs_pkg::BIFS_CODE_OFF;
            ST_PREPURGE: o_code <= bifs_pkg::BIFS_CODE_PURGE;
            ST_POSTPURGE: o_code <= bifs_pkg::BIFS_CODE_PURGE;
            ST_TRIAL: o_code <= bifs_pkg::BIFS_CODE_IGNITION;
            ST_WARMUP: o_code <= bifs_pkg::BIFS_CODE_WARMUP;
            ST_RUN: o_code <= bifs_pkg::BIFS_CODE_RUN;
            ST_RETRY: o_code <= bifs_pkg::BIFS_CODE_RETRY;
            ST_LOCKOUT: o_code <= lock_code;
         endcase
      end
   end

endmodule : bifs_sequencer

/* File: rtl/bifs_pkg.sv */
// Purpose: Shared constants and types for the burner ignition fault sequencer
// Assumes: 125 MHz system clock, power-on reset is the only reset
// Notes: Display codes are small enumerated values decoded by the panel
package bifs_pkg;

   // ************************************************
   // Timing
   // ************************************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_CYCLES = CLK_HZ;
   localparam int unsigned SEC_W = 12;
   localparam logic [11:0] INTERPURGE_S = 12'h01E;
   localparam logic [11:0] PREPURGE_S = 12'h014;
   localparam logic [11:0] POSTPURGE_S = 12'h03C;
   localparam logic [11:0] BOARD_CHECK_S = 12'h00A;
   localparam logic [11:0] WARMUP_S = 12'h00A;
   localparam logic [11:0] TRIAL_S = 12'h004;
   localparam logic [11:0] LOCK_HOUR_S = 12'hE10;
   localparam logic [11:0] LOCK_30_S = 12'h01E;
   localparam logic [11:0] LOCK_10_S = 12'h00A;
   localparam logic [11:0] LOCK_0_S = 12'h000;
   localparam logic [2:0] MAX_TRIALS = 3'h4;

   // ************************************************
   // Analog thresholds (raw units of the sensing front end)
   // ************************************************
   localparam logic [7:0] WEAK_FLAME_NA = 8'h0F;
   localparam logic [7:0] LOW_FIRE_LIMIT = 8'h14;
   localparam logic [7:0] LIMITED_FLOOR = 8'h28;
   localparam logic [7:0] DERATE_PCT = 8'h14;
   localparam logic [7:0] PCT_FULL = 8'h64;

   // ************************************************
   // Display codes
   // ************************************************
   typedef enum logic [4:0] {
      BIFS_CODE_BOARD_CHECK = 5'h00,
      BIFS_CODE_OFF = 5'h01,
      BIFS_CODE_PURGE = 5'h02,
      BIFS_CODE_IGNITION = 5'h03,
      BIFS_CODE_WARMUP = 5'h04,
      BIFS_CODE_RUN = 5'h05,
      BIFS_CODE_RETRY = 5'h06,
      BIFS_CODE_LO_FAILED_IGN = 5'h10,
      BIFS_CODE_LO_LIMIT = 5'h11,
      BIFS_CODE_LO_VALVE = 5'h12,
      BIFS_CODE_LO_LOW_AIR = 5'h13,
      BIFS_CODE_LO_HIGH_AIR = 5'h14,
      BIFS_CODE_LO_ENABLE = 5'h15,
      BIFS_CODE_LO_SECONDARY = 5'h16,
      BIFS_CODE_LO_BOARD = 5'h17,
      BIFS_CODE_LO_AIR_SWITCH = 5'h18
   } bifs_code_e;

   // Alert bit positions in the alert vector
   localparam int unsigned AL_FAILED_IGN = 0;
   localparam int unsigned AL_LOST_FLAME = 1;
   localparam int unsigned AL_COMB_AIR = 2;
   localparam int unsigned AL_LIMITED_LOW = 3;
   localparam int unsigned AL_WEAK_FLAME = 4;
   localparam int unsigned AL_INDUCER = 5;
   localparam int unsigned AL_NULL_CHECK = 6;
   localparam int unsigned AL_W = 7;

   // Pin-side contacts and switches
   typedef struct packed {
      logic heat_call;
      logic enable_ok;
      logic flame;
      logic limit_ok;
      logic rollout_ok;
      logic air_switch;
      logic air_low;
      logic air_high;
      logic air_gas_mismatch;
      logic inducer_stuck;
      logic null_bad;
      logic act_at_park;
      logic act_at_full;
      logic board_fail;
      logic sec_lockout;
   } bifs_pins_s;

   // Burner outputs
   typedef struct packed {
      logic inducer;
      logic igniter;
      logic gas_valve;
      logic act_park;
   } bifs_drive_s;

endpackage : bifs_pkg

/* File: rtl/bifs_sec_tick.sv */
// Purpose: One-second enable pulse from the system clock
// Assumes: Single clock domain
// Notes: Pulse lasts one cycle
`timescale 1ns/10ps
module bifs_sec_tick #(
   parameter int unsigned CYCLES = bifs_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Tick
   output logic o_tick
);
   localparam int unsigned CW = $clog2(CYCLES);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= '0;
         o_tick <= 1'b0;
      end else if (cnt == LAST) begin
         cnt <= '0;
         o_tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         o_tick <= 1'b0;
      end
   end
endmodule : bifs_sec_tick

/* File: dv/bifs_seq_assertions.sv */
// Purpose: Port-level checker for the burner sequencer
// Assumes: Pins reach the state three clocks after they change
// Notes: Bound to every sequencer instance at the foot of this file
`timescale 1ns/10ps
module bifs_seq_chk #(
   parameter int unsigned TICK_CYCLES = bifs_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Sequencer inputs
   input wire bifs_pkg::bifs_pins_s i_pins,
   input wire logic [7:0] i_firing_rate_input,
   input wire logic [7:0] i_act_position,
   input wire logic [7:0] i_flame_current,
   // Sequencer outputs
   input wire bifs_pkg::bifs_drive_s o_drive,
   input wire logic [7:0] o_act_cmd,
   input wire bifs_pkg::bifs_code_e o_code,
   input wire logic o_lockout,
   input wire logic [bifs_pkg::AL_W-1:0] o_alerts
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   localparam int unsigned PURGE_MIN = 15 * TICK_CYCLES;
   int unsigned ind_cnt;
   // Saturates so a long inducer run cannot wrap back below the purge figure
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ind_cnt <= 0;
      end else if (!o_drive.inducer) begin
         ind_cnt <= 0;
      end else if (ind_cnt < PURGE_MIN) begin
         ind_cnt <= ind_cnt + 1;
      end
   end
   sequence s_no_enable;
      (!i_pins.enable_ok && i_firing_rate_input != 8'h00) [*4];
   endsequence
   sequence s_call_gone;
      (!i_pins.heat_call) [*4];
   endsequence
   property p_no_enable_fire;
      s_no_enable |=> !o_drive.gas_valve;
   endproperty
   a_no_enable_fire: assert property (p_no_enable_fire)
      else $error("gas open without enable");
   property p_gas_closed_no_call;
      s_call_gone |=> !o_drive.gas_valve;
   endproperty
   a_gas_closed_no_call: assert property (p_gas_closed_no_call)
      else $error("gas open, no call");
   property p_lockout_code;
      $rose(o_lockout) |=> o_code[4];
   endproperty
   a_lockout_code: assert property (p_lockout_code)
      else $error("lockout without code");
   property p_lockout_quiet;
      o_lockout |-> !o_drive.gas_valve && !o_drive.igniter;
   endproperty
   a_lockout_quiet: assert property (p_lockout_quiet)
      else $error("firing in lockout");
   property p_purge_first;
      $rose(o_drive.igniter) |-> ind_cnt >= PURGE_MIN;
   endproperty
   a_purge_first: assert property (p_purge_first)
      else $error("ignition before purge");
   property p_retry_alert;
      o_code == bifs_pkg::BIFS_CODE_RETRY |-> o_alerts[bifs_pkg::AL_FAILED_IGN]
         || o_alerts[bifs_pkg::AL_LOST_FLAME];
   endproperty
   a_retry_alert: assert property (p_retry_alert)
      else $error("retry without alert");
   property p_park_idle;
      o_drive.act_park |-> o_act_cmd == 8'h00;
   endproperty
   a_park_idle: assert property (p_park_idle)
      else $error("parked with command");
   property p_limit_trip;
      $fell(i_pins.limit_ok) |-> ##[1:4] o_lockout;
   endproperty
   a_limit_trip: assert property (p_limit_trip)
      else $error("no lockout on limit");
endmodule : bifs_seq_chk
bind bifs_sequencer bifs_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) i_bifs_seq_chk (.i_sys_clk,
   .i_rst_n, .i_pins, .i_firing_rate_input, .i_act_position, .i_flame_current, .o_drive,
   .o_act_cmd, .o_code, .o_lockout, .o_alerts);

/* File: dv/bifs_plant.sv */
// Purpose: Far-side model: flame rod, air switch and actuator
// Assumes: Flame exists only while gas flows and the bench allows it
// Notes: Feedback moves 1 ns after the clock edge, like the bench
`timescale 1ns/10ps
module bifs_plant (
   // Clock and drive
   input wire logic i_sys_clk,
   input wire bifs_pkg::bifs_drive_s i_drive,
   input wire logic [7:0] i_act_cmd,
   input wire logic i_light,
   // Feedback
   output logic o_flame,
   output logic o_air_switch,
   output logic o_at_park,
   output logic o_at_full,
   output logic [7:0] o_flame_current
);
   initial {o_flame, o_air_switch, o_at_park, o_at_full, o_flame_current} = '0;
   always @(posedge i_sys_clk) begin
      #1;
      o_flame = i_drive.gas_valve & i_light;
      // Switch closes with the inducer, so the air switch check in warm-up and run passes
      o_air_switch = i_drive.inducer;
      o_at_park = i_drive.act_park;
      o_at_full = i_act_cmd == 8'h64;
      o_flame_current = o_flame ? 8'h20 : 8'h00;
   end
endmodule : bifs_plant

/* File: dv/tb_burner_ignition_fault_sequencer.sv */
// Purpose: Self-checking bench for the burner sequencer
// Assumes: One tick every 10 clocks so an hour of lockout fits the run
// Notes: Code changes are matched in order against the driver's notes
`timescale 1ns/10ps
module tb_burner_ignition_fault_sequencer;
   localparam int TK = 10;
   typedef struct {bifs_pkg::bifs_code_e code; int secs;} bifs_note_s;
   bifs_note_s q[$];
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic heat = 1'b0, en = 1'b1, lim = 1'b1, light = 1'b0, lockout;
   logic flame, air_sw, at_park, at_full;
   logic [7:0] rate = 8'h00, flame_cur, act_cmd;
   logic [bifs_pkg::AL_W-1:0] alerts;
   bifs_pkg::bifs_drive_s drive;
   bifs_pkg::bifs_code_e code;
   bifs_pkg::bifs_code_e prev = bifs_pkg::BIFS_CODE_BOARD_CHECK;
   integer seed = 32'hD73A;
   int miscompares = 0, samples_checked = 0, cyc = 0, last = 0;
   bifs_sequencer #(.TICK_CYCLES(TK)) i_bifs_sequencer (.i_sys_clk, .i_rst_n,
      .i_pins({heat, en, flame, lim, lim, air_sw, 5'h00, at_park, at_full, 2'h0}),
      .i_firing_rate_input(rate), .i_act_position(act_cmd), .i_flame_current(flame_cur),
      .o_drive(drive), .o_act_cmd(act_cmd), .o_code(code), .o_lockout(lockout),
      .o_alerts(alerts));
   bifs_plant i_bifs_plant (.i_sys_clk, .i_drive(drive), .i_act_cmd(act_cmd),
      .i_light(light), .o_flame(flame), .o_air_switch(air_sw), .o_at_park(at_park),
      .o_at_full(at_full), .o_flame_current(flame_cur));
   initial forever #4 i_sys_clk = ~i_sys_clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic note(input bifs_pkg::bifs_code_e c, input int s);
      q.push_back('{c, s});
   endtask : note
   task automatic drain;
      for (int k = 0; k < 40000 && q.size() != 0; k++) @(posedge i_sys_clk);
      check(q.size(), 0);
      #1;
   endtask : drain
   task automatic run_up(input int s);
      note(bifs_pkg::BIFS_CODE_IGNITION, s);
      note(bifs_pkg::BIFS_CODE_WARMUP, -4);
      note(bifs_pkg::BIFS_CODE_RUN, 10);
      drain;
   endtask : run_up
   task automatic test_done;
      if (miscompares == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // Hold time of a code is counted from the change that showed it or from the end of reset, whichever is later
   // Negative figures bound the hold in clocks rather than seconds
   always @(negedge i_sys_clk) begin
      bifs_note_s n;
      cyc++;
      if (!i_rst_n) last = cyc;
      if (code !== prev) begin
         if (q.size() == 0) begin
            check(code, 32'h1F);
         end else begin
            n = q.pop_front();
            check(code, n.code);
            if (n.secs > 0) check(cyc - last >= (n.secs - 1) * TK
               && cyc - last <= (n.secs + 1) * TK + 4, 1);
            if (n.secs < 0) check(cyc - last <= -n.secs, 1);
         end
         last = cyc;
         prev = code;
      end
   end
   initial begin
      repeat (10) @(posedge i_sys_clk);
      #1;
      i_rst_n = 1'b1;
      en = 1'b0;
      rate = 8'h15 + 8'($unsigned($random(seed)) % 79);
      note(bifs_pkg::BIFS_CODE_OFF, 10);
      drain;
      en = 1'b1;
      heat = 1'b1;
      note(bifs_pkg::BIFS_CODE_PURGE, 0);
      note(bifs_pkg::BIFS_CODE_IGNITION, 20);
      repeat (3) begin
         note(bifs_pkg::BIFS_CODE_RETRY, 4);
         note(bifs_pkg::BIFS_CODE_IGNITION, 30);
      end
      note(bifs_pkg::BIFS_CODE_LO_FAILED_IGN, 4);
      drain;
      check(lockout, 1);
      check(alerts[bifs_pkg::AL_FAILED_IGN], 1);
      light = 1'b1;
      note(bifs_pkg::BIFS_CODE_PURGE, 3600);
      run_up(20);
      // Low demand at the moment of flame loss arms the low-fire floor
      rate = 8'h01 + 8'($unsigned($random(seed)) % 20);
      light = 1'b0;
      note(bifs_pkg::BIFS_CODE_RETRY, 0);
      drain;
      check(alerts[bifs_pkg::AL_LOST_FLAME], 1);
      check(alerts[bifs_pkg::AL_LIMITED_LOW], 1);
      light = 1'b1;
      rate = 8'h15 + 8'($unsigned($random(seed)) % 79);
      run_up(30);
      check(act_cmd, (rate < bifs_pkg::LIMITED_FLOOR) ? bifs_pkg::LIMITED_FLOOR
         : rate);
      lim = 1'b0;
      note(bifs_pkg::BIFS_CODE_LO_LIMIT, 0);
      drain;
      check(lockout, 1);
      lim = 1'b1;
      note(bifs_pkg::BIFS_CODE_PURGE, 10);
      run_up(20);
      heat = 1'b0;
      note(bifs_pkg::BIFS_CODE_PURGE, 0);
      note(bifs_pkg::BIFS_CODE_OFF, 60);
      drain;
      // Open enable with demand: zero-length lockout, re-evaluated every clock
      en = 1'b0;
      heat = 1'b1;
      note(bifs_pkg::BIFS_CODE_LO_ENABLE, 0);
      note(bifs_pkg::BIFS_CODE_PURGE, -1);
      note(bifs_pkg::BIFS_CODE_LO_ENABLE, -1);
      drain;
      // Power removed for ten seconds, then restored
      note(bifs_pkg::BIFS_CODE_BOARD_CHECK, -1);
      i_rst_n = 1'b0;
      en = 1'b1;
      heat = 1'b0;
      repeat (10 * TK) @(posedge i_sys_clk);
      #1;
      i_rst_n = 1'b1;
      note(bifs_pkg::BIFS_CODE_OFF, 10);
      drain;
      check(lockout, 0);
      test_done;
   end
   initial begin
      repeat (60000) @(posedge i_sys_clk);
      miscompares++;
      test_done;
   end
endmodule : tb_burner_ignition_fault_sequencer
